// ---- src/reset_cause_flag_bank.sv ----
`timescale 1ns/10ps
module reset_cause_flag_bank
	import reset_cause_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire reset_event_t i_event,
	input wire logic i_in_sleep,
	input wire logic i_global_irq_enable,
	input wire logic [12:0] i_pc,
	input wire logic [1:0] i_brownout_mode_config,
	input wire logic i_bor_circuit_ready,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output pc_action_t o_pc_action,
	output logic o_brownout_detect_on,
	output logic o_stack_reset_enable
);
	logic [7:0] cause_r;
	logic memory_violation_flag_r;
	logic software_brownout_enable_r;
	logic timeout_r;
	logic sleep_r;
	logic stack_en_r;
	logic [31:0] aw_addr_r;
	logic aw_have_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_have_r;
	logic wr_fire;
	logic flag_reset;
	logic [7:0] brownout_control_view;
	logic bor_ready_meta_r;
	logic bor_ready_sync_r;

	// decode a byte address into a register index hit
	function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
		hit = (a == 32'(idx) * BYTE_SCALE);
	endfunction

	// flag storage survives every reset except power-on and brown-out; the stack reset enable clears on i_reset
	assign flag_reset = i_event.power_on | i_event.brown_out;
	assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;

	// bor ready only meaningful when the circuit is enabled
	assign o_brownout_detect_on = (i_brownout_mode_config == BOR_MODE_SOFTWARE)
		? software_brownout_enable_r : (i_brownout_mode_config != BOR_MODE_OFF);
	assign brownout_control_view = {software_brownout_enable_r, 6'h00,
		o_brownout_detect_on & bor_ready_sync_r};

	// the analog ready level is not timed to the system clock, so it is
	// brought over through two flops; software sees it two cycles late
	always_ff @(posedge i_clk_sys) begin
		bor_ready_meta_r <= i_bor_circuit_ready;
		bor_ready_sync_r <= bor_ready_meta_r;
	end
	assign o_stack_reset_enable = stack_en_r;

	// write address and data may arrive in either order
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 32'h0000_0000;
		end else if (s_axi_awvalid & s_axi_awready) begin
			aw_have_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			w_have_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			w_have_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_r <= 1'b0;
		end
	end

	assign s_axi_awready = ~aw_have_r;
	assign s_axi_wready = ~w_have_r;

	// write response, slverr for unmapped addresses
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (hit(aw_addr_r, ADDR_BROWNOUT_CONTROL) |
				hit(aw_addr_r, ADDR_RESET_CAUSE_FLAGS) |
				hit(aw_addr_r, ADDR_RESET_CAUSE_FLAGS_TWO) |
				hit(aw_addr_r, ADDR_STATUS_FLAGS) |
				hit(aw_addr_r, ADDR_CORE_CONTROL)) ? AXI_OKAY : AXI_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// software write into the cause flags; events below override it
	logic sw_cause;
	logic sw_two;
	logic sw_bc;
	logic sw_stat;
	logic sw_ctl;
	assign sw_cause = wr_fire & w_strb_r[0] & hit(aw_addr_r,
		ADDR_RESET_CAUSE_FLAGS);
	assign sw_two = wr_fire & w_strb_r[0] & hit(aw_addr_r,
		ADDR_RESET_CAUSE_FLAGS_TWO);
	assign sw_bc = wr_fire & w_strb_r[0] & hit(aw_addr_r,
		ADDR_BROWNOUT_CONTROL);
	assign sw_stat = wr_fire & w_strb_r[0] & hit(aw_addr_r, ADDR_STATUS_FLAGS);
	assign sw_ctl = wr_fire & w_strb_r[0] & hit(aw_addr_r, ADDR_CORE_CONTROL);

	// cause flags: the event of a cycle wins over a software write
	always_ff @(posedge i_clk_sys) begin
		if (i_event.power_on) begin
			cause_r <= CAUSE_POR_VALUE;
		end else if (i_event.brown_out) begin
			// watchdog and power-on flags are left as they were
			cause_r <= CAUSE_BOR_VALUE | (cause_r & CAUSE_BOR_KEEP);
			cause_r[BIT_BROWNOUT] <= 1'b0;
		end else begin
			if (sw_cause) begin
				cause_r <= w_data_r[7:0] & CAUSE_MASK;
			end
			// only the flag of the actual cause moves
			if (i_event.watchdog & ~i_in_sleep) begin
				cause_r[BIT_WDT] <= 1'b0;
			end
			if (i_event.ext_pin) begin
				cause_r[BIT_EXT] <= 1'b0;
			end
			if (i_event.reset_instr) begin
				cause_r[BIT_INSTR] <= 1'b0;
			end
			if (i_event.stack_over) begin
				cause_r[BIT_STACK_OVERFLOW_FLAG] <= 1'b1;
			end
			if (i_event.stack_under) begin
				cause_r[BIT_STACK_UNDERFLOW_FLAG] <= 1'b1;
			end
		end
	end

	// memory-violation flag in the second register
	always_ff @(posedge i_clk_sys) begin
		if (flag_reset) begin
			memory_violation_flag_r <= 1'b1;
		end else if (i_event.mem_violation) begin
			memory_violation_flag_r <= 1'b0;
		end else if (sw_two) begin
			memory_violation_flag_r <= w_data_r[BIT_MEMORY_VIOLATION_FLAG];
		end
	end

	// software brown-out enable, only power-on/brown-out restore it
	always_ff @(posedge i_clk_sys) begin
		if (flag_reset) begin
			software_brownout_enable_r <= 1'b1;
		end else if (sw_bc) begin
			software_brownout_enable_r <= w_data_r[BIT_SOFTWARE_BROWNOUT_ENABLE];
		end
	end

	// timeout and sleep-entered flags
	always_ff @(posedge i_clk_sys) begin
		if (flag_reset) begin
			timeout_r <= 1'b1;
			sleep_r <= 1'b1;
		end else if (i_event.watchdog) begin
			timeout_r <= 1'b0;
			if (i_in_sleep) begin
				sleep_r <= 1'b0;
			end
		end else if (i_event.ext_pin & i_in_sleep) begin
			timeout_r <= 1'b1;
			sleep_r <= 1'b0;
		end else if (i_event.irq_wake) begin
			timeout_r <= 1'b1;
			sleep_r <= 1'b0;
		end else if (sw_stat) begin
			timeout_r <= w_data_r[BIT_TIMEOUT];
			sleep_r <= w_data_r[BIT_SLEEP];
		end
	end

	// stack reset enable is a software control bit
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			stack_en_r <= 1'b0;
		end else if (sw_ctl) begin
			stack_en_r <= w_data_r[0];
		end
	end

	// program counter action: sleep wake-ups resume at pc+1 or jump to the irq vector, others go to zero
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_pc_action <= '0;
		end else if ((i_event.watchdog | i_event.irq_wake) & i_in_sleep) begin
			o_pc_action.load <= 1'b1;
			o_pc_action.push_return <= i_event.irq_wake &
				~i_event.watchdog & i_global_irq_enable;
			o_pc_action.target <= (i_event.irq_wake & ~i_event.watchdog &
				i_global_irq_enable) ? IRQ_VECTOR : 13'(i_pc + 13'h0001);
		end else if (flag_reset | i_event.watchdog | i_event.ext_pin |
			i_event.reset_instr | i_event.mem_violation |
			((i_event.stack_over | i_event.stack_under) & stack_en_r)) begin
			o_pc_action.load <= 1'b1;
			o_pc_action.push_return <= 1'b0;
			o_pc_action.target <= RESET_VECTOR;
		end else begin
			o_pc_action <= '0;
		end
	end

	// read channel: one outstanding read, answer one cycle after address
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= AXI_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= AXI_OKAY;
			if (hit(s_axi_araddr, ADDR_BROWNOUT_CONTROL)) begin
				s_axi_rdata <= {24'h00_0000, brownout_control_view};
			end else if (hit(s_axi_araddr, ADDR_RESET_CAUSE_FLAGS)) begin
				s_axi_rdata <= {24'h00_0000, cause_r & CAUSE_MASK};
			end else if (hit(s_axi_araddr, ADDR_RESET_CAUSE_FLAGS_TWO)) begin
				s_axi_rdata <= {30'h0000_0000, memory_violation_flag_r, 1'b0};
			end else if (hit(s_axi_araddr, ADDR_STATUS_FLAGS)) begin
				s_axi_rdata <= {30'h0000_0000, timeout_r, sleep_r};
			end else if (hit(s_axi_araddr, ADDR_CORE_CONTROL)) begin
				s_axi_rdata <= {31'h0000_0000, stack_en_r};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= AXI_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ---- src/reset_cause_pkg.sv ----
package reset_cause_pkg;
	localparam logic [15:0] ADDR_BROWNOUT_CONTROL = 16'h0191;
	localparam logic [15:0] ADDR_RESET_CAUSE_FLAGS = 16'h0192;
	localparam logic [15:0] ADDR_RESET_CAUSE_FLAGS_TWO = 16'h0193;
	localparam logic [15:0] ADDR_STATUS_FLAGS = 16'h0194;
	localparam logic [15:0] ADDR_CORE_CONTROL = 16'h0195;
	localparam logic [31:0] BYTE_SCALE = 32'h0000_0004;
	// bit positions in the cause, second, brown-out control and status registers
	localparam int BIT_STACK_OVERFLOW_FLAG = 7;
	localparam int BIT_STACK_UNDERFLOW_FLAG = 6;
	localparam int BIT_WDT = 4;
	localparam int BIT_EXT = 3;
	localparam int BIT_INSTR = 2;
	localparam int BIT_POWERON = 1;
	localparam int BIT_BROWNOUT = 0;
	localparam int BIT_MEMORY_VIOLATION_FLAG = 1;
	localparam int BIT_SOFTWARE_BROWNOUT_ENABLE = 7;
	localparam int BIT_BROWNOUT_READY = 0;
	localparam int BIT_TIMEOUT = 1;
	localparam int BIT_SLEEP = 0;
	localparam logic [7:0] CAUSE_MASK = 8'hdf;
	localparam logic [7:0] CAUSE_POR_VALUE = 8'h3c;
	// brown-out clears both stack flags and re-arms pin and instruction flags
	localparam logic [7:0] CAUSE_BOR_VALUE = 8'h2c;
	// watchdog and power-on flags survive a brown-out untouched
	localparam logic [7:0] CAUSE_BOR_KEEP = 8'h12;
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam logic [1:0] BOR_MODE_SOFTWARE = 2'b01;
	localparam logic [1:0] BOR_MODE_OFF = 2'b00;
	localparam logic [1:0] AXI_OKAY = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;

	// event strobes from reset sources and the core, one-cycle pulses
	typedef struct packed {
		logic power_on;
		logic brown_out;
		logic ext_pin;
		logic watchdog;
		logic reset_instr;
		logic stack_over;
		logic stack_under;
		logic mem_violation;
		logic irq_wake;
	} reset_event_t;

	// program counter action handed to the core
	typedef struct packed {
		logic load;
		logic push_return;
		logic [12:0] target;
	} pc_action_t;
endpackage

// ---- verif/reset_source_model.sv ----
`timescale 1ns/10ps
module reset_source_model
	import reset_cause_pkg::*;
(
	input wire logic i_clk_sys,
	output reset_event_t o_event,
	output logic o_in_sleep,
	output logic [12:0] o_pc
);
	initial begin
		o_event = '0;
		o_in_sleep = 1'b0;
		o_pc = 13'h0000;
	end
	// the core steps every cycle so a resume address differs from the vector
	always @(posedge i_clk_sys) begin
		o_pc <= o_pc + 13'h0001;
	end
	// one source fires a single-cycle strobe, sleep held only around it
	task automatic fire(input int idx, input logic s);
		@(posedge i_clk_sys);
		o_in_sleep <= s;
		o_event <= reset_event_t'(9'h001 << idx);
		@(posedge i_clk_sys);
		o_event <= '0;
		o_in_sleep <= 1'b0;
	endtask
endmodule

// ---- verif/flag_bank_assertions.sv ----
`timescale 1ns/10ps
module flag_bank_assertions
	import reset_cause_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire reset_event_t i_event,
	input wire logic i_in_sleep,
	input wire logic i_global_irq_enable,
	input wire logic [12:0] i_pc,
	input wire logic [1:0] i_brownout_mode_config,
	input wire pc_action_t o_pc_action,
	input wire logic o_brownout_detect_on,
	input wire logic o_stack_reset_enable
);
	// single domain, so clock and reset are stated once
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	a_pin_restart:
	assert property (i_event.ext_pin && !i_in_sleep |=> o_pc_action.load &&
		o_pc_action.target == RESET_VECTOR) else $error("pin pc wrong");
	a_instr_restart:
	assert property (i_event.reset_instr |=> o_pc_action.load &&
		o_pc_action.target == RESET_VECTOR) else $error("instr pc wrong");
	a_wdt_wake_next:
	assert property (i_event.watchdog && i_in_sleep |=> o_pc_action.load &&
		o_pc_action.target == $past(i_pc) + 13'h0001) else $error("wake pc");
	a_irq_vector:
	assert property (i_event.irq_wake && i_in_sleep && i_global_irq_enable
		|=> o_pc_action.push_return && o_pc_action.target == IRQ_VECTOR)
		else $error("irq vector wrong");
	a_irq_resume_next:
	assert property (i_event.irq_wake && i_in_sleep && !i_global_irq_enable
		|=> o_pc_action.load && !o_pc_action.push_return &&
		o_pc_action.target == $past(i_pc) + 13'h0001)
		else $error("irq resume pc wrong");
	a_stack_gated:
	assert property (i_event.stack_over && o_stack_reset_enable |=>
		o_pc_action.load && o_pc_action.target == RESET_VECTOR)
		else $error("stack pc wrong");
	a_load_pulse:
	assert property (o_pc_action.load |=> !o_pc_action.load)
		else $error("load not a pulse");
	a_bor_off_mode:
	assert property (i_brownout_mode_config == BOR_MODE_OFF |->
		!o_brownout_detect_on) else $error("bor on in mode 00");
	a_bor_fixed_on:
	assert property (i_brownout_mode_config == 2'b11 |->
		o_brownout_detect_on) else $error("bor off in mode 11");
endmodule
bind reset_cause_flag_bank flag_bank_assertions chk (.i_clk_sys(i_clk_sys),
	.i_reset(i_reset), .i_event(i_event), .i_in_sleep(i_in_sleep),
	.i_global_irq_enable(i_global_irq_enable), .i_pc(i_pc),
	.i_brownout_mode_config(i_brownout_mode_config),
	.o_pc_action(o_pc_action), .o_brownout_detect_on(o_brownout_detect_on),
	.o_stack_reset_enable(o_stack_reset_enable));

// ---- verif/tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++;\
 $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module tb;
	import reset_cause_pkg::*;
	localparam logic [15:0] CA = ADDR_RESET_CAUSE_FLAGS;
	localparam logic [15:0] ST = ADDR_STATUS_FLAGS;
	localparam logic [15:0] C2 = ADDR_RESET_CAUSE_FLAGS_TWO;
	localparam logic [15:0] BC = ADDR_BROWNOUT_CONTROL;
	logic clk = 0, rst = 1, global_irq_enable = 1, rdy = 1, awv = 0, wv = 0, bq = 0;
	logic arv = 0, rq = 0, awr, wrd, bv, arr, rv, bon, sen, slp;
	logic [1:0] mode = 2'b01, br, rr, rsp;
	logic [31:0] awa = 0, wd = 0, ara = 0, rd_o, got;
	logic [12:0] pc;
	reset_event_t ev;
	pc_action_t pca;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	int loads = 0, n = 0;
	// per event: strobe bit, sleep, expected cause and status
	int idx[9] = '{5, 5, 0, 6, 4, 3, 2, 1, 7};
	logic sl[9] = '{0, 1, 1, 1, 0, 0, 0, 0, 0};
	logic [7:0] ec[9] = '{8'h0f, 8'h1f, 8'h1f, 8'h17, 8'h1b, 8'h9f, 8'h5f,
		8'h1f, 8'h1e};
	logic [7:0] es[9] = '{8'h01, 8'h00, 8'h02, 8'h02, 8'h03, 8'h03, 8'h03,
		8'h03, 8'h03};
	reset_cause_flag_bank dut (.i_clk_sys(clk), .i_reset(rst), .i_event(ev),
		.i_in_sleep(slp), .i_global_irq_enable(global_irq_enable), .i_pc(pc),
		.i_brownout_mode_config(mode), .i_bor_circuit_ready(rdy),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bq), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd_o), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rq), .o_pc_action(pca),
		.o_brownout_detect_on(bon), .o_stack_reset_enable(sen));
	reset_source_model ps (.i_clk_sys(clk), .o_event(ev), .o_in_sleep(slp),
		.o_pc(pc));
	initial begin
		forever #50 clk = ~clk;
	end
	// handshakes are sampled at the fall, so they match what the rise sees
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic ha, hw, hb;
		@(posedge clk);
		awa <= {14'h0, a, 2'b00};
		wd <= {24'h0, d};
		awv <= 1;
		wv <= 1;
		bq <= 1;
		do begin
			@(negedge clk);
			ha = awv && awr;
			hw = wv && wrd;
			hb = bv;
			@(posedge clk);
			if (ha) awv <= 0;
			if (hw) wv <= 0;
		end while (!hb);
		bq <= 0;
	endtask
	task automatic rd(input logic [15:0] a);
		logic ha, hr;
		@(posedge clk);
		ara <= {14'h0, a, 2'b00};
		arv <= 1;
		rq <= 1;
		do begin
			@(negedge clk);
			ha = arv && arr;
			hr = rv;
			got = rd_o;
			rsp = rr;
			@(posedge clk);
			if (ha) arv <= 0;
		end while (!hr);
		rq <= 0;
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		rd(a);
		`CHK(got, {24'h0, e})
	endtask
	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// count program counter loads, sampled where the pulse is settled
	always @(negedge clk) begin
		if (pca.load) loads++;
	end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		ps.fire(8, 0);
		rc(CA, 8'h1c);
		rc(ST, 8'h03);
		rc(C2, 8'h02);
		rc(BC, 8'h81);
		wr(ADDR_CORE_CONTROL, 8'h01);
		ps.fire(6, 0);
		rc(CA, 8'h14);
		n = loads;
		wr(CA, 8'hff);
		repeat (2) @(posedge clk);
		`CHK(loads, n)
		rc(CA, 8'hdf);
		wr(CA, 8'h00);
		rc(CA, 8'h00);
		@(posedge clk) rst <= 1;
		@(posedge clk) rst <= 0;
		rc(CA, 8'h00);
		wr(ADDR_CORE_CONTROL, 8'h01);
		`CHK(sen, 1'b1)
		for (int i = 0; i < 9; i++) begin
			wr(CA, 8'h1f);
			wr(ST, 8'h03);
			wr(C2, 8'h02);
			ps.fire(idx[i], sl[i]);
			rc(CA, ec[i]);
			rc(ST, es[i]);
			rc(C2, idx[i] == 1 ? 8'h00 : 8'h02);
		end
		wr(BC, 8'h00);
		rc(BC, 8'h00);
		`CHK(bon, 1'b0)
		@(posedge clk) mode <= 2'b11;
		rc(BC, 8'h01);
		`CHK(bon, 1'b1)
		@(posedge clk) rdy <= 0;
		repeat (2) @(posedge clk);
		rc(BC, 8'h00);
		wr(BC, 8'h80);
		@(posedge clk) mode <= 2'b00;
		rc(BC, 8'h80);
		`CHK(bon, 1'b0)
		rd(16'h01c0);
		`CHK(rsp, AXI_SLVERR)
		`CHK(got, 32'h0000_0000)
		@(posedge clk) global_irq_enable <= 0;
		ps.fire(0, 1);
		rc(ST, 8'h02);
		ps.fire(8, 0);
		rc(CA, 8'h1c);
		conclude();
	end
endmodule
